// File: rtl/ceac_top.sv
// can error and arbitration capture with axi4-lite register access
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ceac_params.svh"
module ceac_top (
  input wire logic aclk, // system clock, 100 MHz
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire ceac_pkg::ceac_err_evt_t err_evt, // bus error event
  input wire ceac_pkg::ceac_arb_evt_t arb_evt // arbitration loss event
);

  ////////////////////////////////////////////////////////////////////
  // address decode, shared by the read and the write path
  function automatic ceac_pkg::ceac_sel_t sel_of(input logic [7:0] addr);
    case (addr)
      `CEAC_OFF_CAPTURE: sel_of = ceac_pkg::CEAC_SEL_CAP;
      `CEAC_OFF_CTRL: sel_of = ceac_pkg::CEAC_SEL_CTRL;
      `CEAC_OFF_COUNT: sel_of = ceac_pkg::CEAC_SEL_CNT;
      default: sel_of = ceac_pkg::CEAC_SEL_NONE;
    endcase
  endfunction : sel_of

  ceac_pkg::ceac_top_st_t st_r; // registered state
  ceac_pkg::ceac_top_st_t st_nxt; // next state

  logic aw_hs; // write address taken
  logic w_hs; // write data taken
  logic b_hs; // write response taken
  logic ar_hs; // read address taken
  logic r_hs; // read data taken
  logic start; // first cycle of communication
  logic rd_clr; // read of the capture word
  logic err_take; // bus error while communicating
  logic err_cap; // bus error eligible for capture
  logic arb_take; // arbitration loss while communicating
  logic [7:0] err_byte_in; // error details packed as a byte
  logic [7:0] arb_byte_in; // loss position packed as a byte
  logic [7:0] err_q; // held error byte
  logic err_fresh; // error record new
  logic [7:0] arb_q; // held arbitration byte
  logic arb_fresh; // arbitration record new
  logic [7:0] tx_cnt; // transmit error count
  logic [7:0] rx_cnt; // receive error count
  logic [31:0] cap_word; // packed capture word

  ////////////////////////////////////////////////////////////////////
  // handshakes and event qualification
  assign aw_hs = s_axi_awvalid && st_r.awready;
  assign w_hs = s_axi_wvalid && st_r.wready;
  assign b_hs = st_r.bvalid && s_axi_bready;
  assign ar_hs = s_axi_arvalid && st_r.arready;
  assign r_hs = st_r.rvalid && s_axi_rready;

  // communication starts on the rising enable; records begin empty
  assign start = st_r.comm_en && !st_r.comm_en_d;

  // one read takes both records and re-arms both
  assign rd_clr = ar_hs && (sel_of(s_axi_araddr) == ceac_pkg::CEAC_SEL_CAP);

  // events before the start are not recorded at all
  assign err_take = err_evt.valid && st_r.comm_en;
  // a code of zero would read back as no error, so it is not latched
  assign err_cap = err_take &&
    (err_evt.error_segment_code != ceac_pkg::CEAC_SEG_NONE);
  // arbitration loss goes to its own record only
  assign arb_take = arb_evt.valid && st_r.comm_en;

  // byte layout: segment 4:0, direction 5, type 7:6
  assign err_byte_in = {err_evt.error_type, err_evt.dir,
    err_evt.error_segment_code};
  // position in the low five bits, upper bits zero
  assign arb_byte_in = {3'h0, arb_evt.arbitration_loss_position};

  ////////////////////////////////////////////////////////////////////
  // the two capture records
  ceac_capture u_err_cap (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start),
    .evt(err_cap),
    .evt_data(err_byte_in),
    .rd_clr(rd_clr),
    .cap_data(err_q),
    .cap_fresh(err_fresh)
  );

  ceac_capture u_arb_cap (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start),
    .evt(arb_take),
    .evt_data(arb_byte_in),
    .rd_clr(rd_clr),
    .cap_data(arb_q),
    .cap_fresh(arb_fresh)
  );

  // error counters see bus errors only, never arbitration loss
  ceac_counters u_cnt (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start),
    .err(err_take),
    .dir(err_evt.dir),
    .tx_cnt(tx_cnt),
    .rx_cnt(rx_cnt)
  );

  ////////////////////////////////////////////////////////////////////
  // packed capture word; everything not listed stays zero
  always_comb begin
    cap_word = 32'h0000_0000;
    cap_word[`CEAC_ERR_LSB +: 8] = err_q;
    cap_word[`CEAC_ARB_LSB +: 8] = arb_q;
    cap_word[`CEAC_ERR_FRESH_BIT] = err_fresh;
    cap_word[`CEAC_ARB_FRESH_BIT] = arb_fresh;
  end

  ////////////////////////////////////////////////////////////////////
  // bus slave next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.comm_en_d = st_r.comm_en;
    // address and data may come in either order
    if (aw_hs) begin
      st_nxt.aw_addr = s_axi_awaddr;
      st_nxt.aw_held = 1'b1;
    end
    if (w_hs) begin
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
      st_nxt.w_held = 1'b1;
    end
    // both halves present: perform the write and answer
    if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
      case (sel_of(st_r.aw_addr))
        ceac_pkg::CEAC_SEL_CTRL: begin
          // only the low lane holds the enable bit
          if (st_r.w_strb[0]) begin
            st_nxt.comm_en = st_r.w_data[`CEAC_CTRL_EN_BIT];
          end
          st_nxt.bresp = `CEAC_RESP_OKAY;
        end
        ceac_pkg::CEAC_SEL_CAP,
        ceac_pkg::CEAC_SEL_CNT: begin
          // read-only words: write dropped, answered okay
          st_nxt.bresp = `CEAC_RESP_OKAY;
        end
        default: begin
          st_nxt.bresp = `CEAC_RESP_SLVERR;
        end
      endcase
      st_nxt.bvalid = 1'b1;
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
    end
    if (b_hs) begin
      st_nxt.bvalid = 1'b0;
    end
    // one write in flight: no new halves until the answer is gone
    st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;
    // read path: data sampled in the cycle the address is taken
    if (ar_hs) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = `CEAC_RESP_OKAY;
      case (sel_of(s_axi_araddr))
        ceac_pkg::CEAC_SEL_CAP: begin
          st_nxt.rdata = cap_word;
        end
        ceac_pkg::CEAC_SEL_CTRL: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rdata[`CEAC_CTRL_EN_BIT] = st_r.comm_en;
        end
        ceac_pkg::CEAC_SEL_CNT: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rdata[`CEAC_TX_CNT_LSB +: 8] = tx_cnt;
          st_nxt.rdata[`CEAC_RX_CNT_LSB +: 8] = rx_cnt;
        end
        default: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = `CEAC_RESP_SLVERR;
        end
      endcase
    end
    if (r_hs) begin
      st_nxt.rvalid = 1'b0;
    end
    // one read in flight at a time
    st_nxt.arready = !st_nxt.rvalid;
  end

  // state register; readies rise one edge after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state flops
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rvalid = st_r.rvalid;

  ////////////////////////////////////////////////////////////////////
  // checks on the capture behaviour
  AST_ERR_LATCH: assert property (@(posedge aclk) disable iff (!aresetn)
    (err_cap && !start && (!err_fresh || rd_clr))
    |=> err_fresh && (err_q == $past(err_byte_in)))
    else $error("bus error not latched into the error record");

  AST_ARB_LATCH: assert property (@(posedge aclk) disable iff (!aresetn)
    (arb_take && !start && (!arb_fresh || rd_clr))
    |=> arb_fresh && (arb_q == $past(arb_byte_in)))
    else $error("arbitration loss not latched into its record");

  AST_ARB_NO_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
    (arb_take && !err_take && !start) |=> $stable(tx_cnt) && $stable(rx_cnt))
    else $error("arbitration loss moved an error counter");

  AST_WORD_BYTES: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_clr |=> s_axi_rvalid && (s_axi_rdata[7:0] == $past(err_q))
    && (s_axi_rdata[15:8] == $past(arb_q)))
    else $error("capture bytes misplaced in the read word");

  AST_WORD_FLAGS: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_clr |=> (s_axi_rdata[16] == $past(err_fresh))
    && (s_axi_rdata[17] == $past(arb_fresh)))
    else $error("fresh flags misplaced in the read word");

  AST_READ_REARM: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_clr && !err_cap && !arb_take) |=> !err_fresh && !arb_fresh)
    else $error("read did not clear both fresh flags");

  AST_START_EMPTY: assert property (@(posedge aclk) disable iff (!aresetn)
    start |=> (err_q == 8'h00) && !err_fresh && (arb_q == 8'h00) && !arb_fresh)
    else $error("records not empty at communication start");

  AST_RSV_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_clr |=> (s_axi_rdata[31:18] == 14'h0000))
    else $error("reserved bits of the capture word not zero");

  AST_NONE_SKIP: assert property (@(posedge aclk) disable iff (!aresetn)
    (err_take && (err_evt.error_segment_code == ceac_pkg::CEAC_SEG_NONE)
    && !err_fresh && !start) |=> !err_fresh)
    else $error("error with empty segment code was latched");

  AST_READ_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered one cycle after address");

  ////////////////////////////////////////////////////////////////////
  // checks on the records, on counting, on the quiet state before the start and on read answers
  // an error record of code zero is never marked fresh
  AST_ZERO_STALE: assert property (@(posedge aclk) disable iff (!aresetn)
    (err_q[4:0] == 5'h00) |-> !err_fresh)
    else $error("fresh error record with empty segment code");

  // arbitration loss leaves the error record alone
  AST_ARB_NO_ERR_REC: assert property (@(posedge aclk) disable iff (!aresetn)
    (arb_take && !err_cap && !start && !rd_clr) |=> $stable(err_q) && $stable(err_fresh))
    else $error("arbitration loss changed the error record");

  // every bus error moves one counter unless a counter is already full
  AST_ERR_COUNTS: assert property (@(posedge aclk) disable iff (!aresetn)
    (err_take && !start && (tx_cnt != `CEAC_CNT_MAX) && (rx_cnt != `CEAC_CNT_MAX))
    |=> $changed(tx_cnt) || $changed(rx_cnt))
    else $error("bus error left both counters unchanged");

  // nothing turns fresh while communication is off
  AST_IDLE_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
    (!st_r.comm_en && !err_fresh && !arb_fresh) |=> !err_fresh && !arb_fresh)
    else $error("record marked fresh while communication is off");

  // a read of the capture word always answers okay
  AST_READ_OKAY: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_clr |=> (s_axi_rresp == `CEAC_RESP_OKAY))
    else $error("capture word read not answered okay");
endmodule : ceac_top
`default_nettype wire

// File: rtl/ceac_params.svh
// constants of the can error and arbitration capture block
// Functional notes
// - latch first bus error, hold until read
// - latch first arbitration loss, hold until read
// - each bus error bumps tx or rx counter unless that counter is already full
// - arbitration loss never touches error counters
// - error byte bits 0-7, arbitration byte 8-15
// - error fresh bit 16, arbitration fresh 17
// - fresh flag marks content new since read
// - segment code zero means no error recorded
// - segment codes for identifier bit groups
// - segment codes for frame fields
// - segment codes for delimiters and flags
// - direction zero transmit, one receive
// - error type bit, form, stuff, other
// - loss positions 0-12 base identifier, SRTR, IDE
// - loss positions 13-31 extended identifier, RTR
// - no error since start reads all zero
// - arbitration fresh flag marks new position
`ifndef CEAC_PARAMS_SVH
`define CEAC_PARAMS_SVH
// register byte offsets
`define CEAC_OFF_CAPTURE 8'h00
`define CEAC_OFF_CTRL 8'h04
`define CEAC_OFF_COUNT 8'h08
// capture word layout
`define CEAC_ERR_LSB 0
`define CEAC_ARB_LSB 8
`define CEAC_ERR_FRESH_BIT 16
`define CEAC_ARB_FRESH_BIT 17
// control and counter layout
`define CEAC_CTRL_EN_BIT 0
`define CEAC_TX_CNT_LSB 0
`define CEAC_RX_CNT_LSB 8
// reset values and limits
`define CEAC_CAP_RST 8'h00
`define CEAC_CNT_RST 8'h00
`define CEAC_CNT_MAX 8'hFF
`define CEAC_CTRL_EN_RST 1'b0
// bus answers
`define CEAC_RESP_OKAY 2'h0
`define CEAC_RESP_SLVERR 2'h2
`endif

// File: rtl/ceac_pkg.sv
// types of the can error and arbitration capture block
package ceac_pkg;
  // error segment codes, zero means nothing recorded
  typedef enum logic [4:0] {
    CEAC_SEG_NONE = 5'h00,
    CEAC_SEG_ID28_21 = 5'h02,
    CEAC_SEG_SOF = 5'h03,
    CEAC_SEG_SRTR = 5'h04,
    CEAC_SEG_IDE = 5'h05,
    CEAC_SEG_ID20_18 = 5'h06,
    CEAC_SEG_ID17_13 = 5'h07,
    CEAC_SEG_CRC = 5'h08,
    CEAC_SEG_RSV0 = 5'h09,
    CEAC_SEG_DATA = 5'h0A,
    CEAC_SEG_DLC = 5'h0B,
    CEAC_SEG_XRTR = 5'h0C,
    CEAC_SEG_RSV1 = 5'h0D,
    CEAC_SEG_ID4_0 = 5'h0E,
    CEAC_SEG_ID12_5 = 5'h0F,
    CEAC_SEG_ACT_FLAG = 5'h11,
    CEAC_SEG_INTERMISSION = 5'h12,
    CEAC_SEG_TOL_DOM = 5'h13,
    CEAC_SEG_PAS_FLAG = 5'h16,
    CEAC_SEG_ERR_DELIM = 5'h17,
    CEAC_SEG_CRC_DELIM = 5'h18,
    CEAC_SEG_ACK_SLOT = 5'h19,
    CEAC_SEG_EOF = 5'h1A,
    CEAC_SEG_ACK_DELIM = 5'h1B,
    CEAC_SEG_OVL_FLAG = 5'h1C
  } ceac_seg_t;
  // direction of the failing frame
  typedef enum logic {
    CEAC_DIR_TX = 1'b0,
    CEAC_DIR_RX = 1'b1
  } ceac_dir_t;
  // error kind
  typedef enum logic [1:0] {
    CEAC_ERR_BIT = 2'h0,
    CEAC_ERR_FORM = 2'h1,
    CEAC_ERR_STUFF = 2'h2,
    CEAC_ERR_OTHER = 2'h3
  } ceac_etype_t;
  // loss position: 0-10 id.28..18, 11 srtr, 12 ide, 13-30 id.17..0, 31 rtr
  typedef logic [4:0] ceac_alpos_t;
  // register selected by an address
  typedef enum logic [1:0] {
    CEAC_SEL_CAP = 2'h0,
    CEAC_SEL_CTRL = 2'h1,
    CEAC_SEL_CNT = 2'h2,
    CEAC_SEL_NONE = 2'h3
  } ceac_sel_t;
  // bus error event from the protocol engine
  typedef struct packed {
    logic valid; // one-cycle pulse
    ceac_etype_t error_type;
    ceac_dir_t dir;
    ceac_seg_t error_segment_code;
  } ceac_err_evt_t;
  // arbitration loss event from the protocol engine
  typedef struct packed {
    logic valid; // one-cycle pulse
    ceac_alpos_t arbitration_loss_position;
  } ceac_arb_evt_t;
  // state of one capture record
  typedef struct packed {
    logic [7:0] data;
    logic fresh;
  } ceac_cap_st_t;
  // state of the error counters
  typedef struct packed {
    logic [7:0] tx;
    logic [7:0] rx;
  } ceac_cnt_st_t;
  // state of the top level
  typedef struct packed {
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic comm_en;
    logic comm_en_d;
  } ceac_top_st_t;
endpackage : ceac_pkg

// File: rtl/ceac_capture.sv
// one capture record: latch, freeze until read, re-arm
`timescale 1ns/10ps
`default_nettype none
`include "ceac_params.svh"
module ceac_capture (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic start, // communication start, clears record
  input wire logic evt, // event to capture
  input wire logic [7:0] evt_data, // event details
  input wire logic rd_clr, // host read of the word
  output logic [7:0] cap_data, // held details
  output logic cap_fresh // record new since last read
);
  ceac_pkg::ceac_cap_st_t st_r; // registered state
  ceac_pkg::ceac_cap_st_t st_nxt; // next state

  ////////////////////////////////////////////////////////////////////
  // next state: read clears the flag, a new event in that cycle wins
  always_comb begin
    st_nxt = st_r;
    if (rd_clr) begin
      st_nxt.fresh = 1'b0;
    end
    if (start) begin
      st_nxt.data = `CEAC_CAP_RST;
      st_nxt.fresh = 1'b0;
    end else if (evt && (!st_r.fresh || rd_clr)) begin
      st_nxt.data = evt_data;
      st_nxt.fresh = 1'b1;
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cap_data = st_r.data;
  assign cap_fresh = st_r.fresh;

  ////////////////////////////////////////////////////////////////////
  AST_CAP_FROZEN: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.fresh && !rd_clr && !start) |=> $stable(st_r.data) && st_r.fresh)
    else $error("held capture changed before a read");
endmodule : ceac_capture
`default_nettype wire

// File: rtl/ceac_counters.sv
// transmit and receive error counters, saturating
`timescale 1ns/10ps
`default_nettype none
`include "ceac_params.svh"
module ceac_counters (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic start, // communication start, clears counts
  input wire logic err, // bus error pulse
  input wire ceac_pkg::ceac_dir_t dir, // direction of that error
  output logic [7:0] tx_cnt, // transmit error count
  output logic [7:0] rx_cnt // receive error count
);
  ceac_pkg::ceac_cnt_st_t st_r; // registered state
  ceac_pkg::ceac_cnt_st_t st_nxt; // next state

  ////////////////////////////////////////////////////////////////////
  // next state: one counter moves per error, held at the top value
  always_comb begin
    st_nxt = st_r;
    if (start) begin
      st_nxt.tx = `CEAC_CNT_RST;
      st_nxt.rx = `CEAC_CNT_RST;
    end else if (err) begin
      if (dir == ceac_pkg::CEAC_DIR_TX) begin
        if (st_r.tx != `CEAC_CNT_MAX) st_nxt.tx = st_r.tx + 8'h01;
      end else begin
        if (st_r.rx != `CEAC_CNT_MAX) st_nxt.rx = st_r.rx + 8'h01;
      end
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tx_cnt = st_r.tx;
  assign rx_cnt = st_r.rx;

  ////////////////////////////////////////////////////////////////////
  AST_CNT_TX_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
    (err && !start && dir == ceac_pkg::CEAC_DIR_TX && st_r.tx != `CEAC_CNT_MAX)
    |=> (st_r.tx == $past(st_r.tx) + 8'h01) && $stable(st_r.rx))
    else $error("transmit error did not step tx count");
  AST_CNT_RX_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
    (err && !start && dir == ceac_pkg::CEAC_DIR_RX && st_r.rx != `CEAC_CNT_MAX)
    |=> (st_r.rx == $past(st_r.rx) + 8'h01) && $stable(st_r.tx))
    else $error("receive error did not step rx count");
endmodule : ceac_counters

// File: verification/ceac_bus_model.sv
// model of the other bus nodes: emits one-cycle error and arbitration events
`timescale 1ns/10ps
`default_nettype none
module ceac_bus_model (
  input wire logic aclk, // system clock
  input wire logic fire_err, // request one bus error event
  input wire logic [7:0] err_det, // packed {type, dir, segment}
  input wire logic fire_arb, // request one arbitration loss event
  input wire logic [4:0] arb_pos, // bit position where arbitration was lost
  output var ceac_pkg::ceac_err_evt_t err_evt, // error event toward the block
  output var ceac_pkg::ceac_arb_evt_t arb_evt // arbitration event toward the block
);
  ////////////////////////////////////////////////////////////////////////////
  // pulses last one cycle; idle fields show the inverse so stale data never looks valid
  always_ff @(posedge aclk) begin
    err_evt <= {fire_err, fire_err ? err_det : ~err_det};
    arb_evt <= {fire_arb, fire_arb ? arb_pos : ~arb_pos};
  end
endmodule : ceac_bus_model
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the capture block over its register bus
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  logic aclk = 1'b0; // system clock
  logic aresetn = 1'b0; // sync reset, active low
  logic [7:0] awaddr = 8'h00, araddr = 8'h00; // bus addresses
  logic [31:0] wdata = 32'h0; // write data
  logic [3:0] wstrb = 4'hF; // write byte strobes
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0; // master
  logic awready, wready, bvalid, arready, rvalid; // slave handshakes
  logic [1:0] bresp, rresp; // slave answers
  logic [31:0] rdata; // read data
  logic fire_err = 1'b0, fire_arb = 1'b0; // event requests to the model
  logic [7:0] err_det = 8'h00; // error details
  logic [4:0] arb_pos = 5'h00; // loss position
  ceac_pkg::ceac_err_evt_t err_evt; // model to block
  ceac_pkg::ceac_arb_evt_t arb_evt; // model to block
  int error_cnt = 0, n_compared = 0, cyc = 0; // score and watchdog
  logic [31:0] d, exp; // read result and expectation
  logic [1:0] r; // response code
  logic [7:0] txn = 8'h00, rxn = 8'h00; // expected error counts
  // table row: error details beside the loss position they go with
  typedef struct packed {logic [7:0] det; logic [4:0] pos;} ceac_row_t;
  ceac_row_t rows [7] = '{'{8'h02, 5'h00}, '{8'h7C, 5'h0A}, '{8'h83, 5'h0B},
    '{8'hE8, 5'h0C}, '{8'h31, 5'h0D}, '{8'hBC, 5'h1E}, '{8'h58, 5'h1F}};

  ////////////////////////////////////////////////////////////////////////////
  ceac_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .err_evt(err_evt), .arb_evt(arb_evt));
  ceac_bus_model u_bus (.aclk(aclk), .fire_err(fire_err), .err_det(err_det),
    .fire_arb(fire_arb), .arb_pos(arb_pos), .err_evt(err_evt), .arb_evt(arb_evt));

  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog; the ceiling is far above the roughly 150 cycles needed
  initial begin
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus write: both channels offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
  endtask : axw
  // bus read: data taken at the edge where rvalid is seen
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    v = rdata;
    resp = rresp;
  endtask : axr
  // ask the model for one event of each selected kind
  task automatic ev(input logic fe, input logic [7:0] dt, input logic fa, input logic [4:0] p);
    @(posedge aclk);
    fire_err <= fe;
    err_det <= dt;
    fire_arb <= fa;
    arb_pos <= p;
    @(posedge aclk);
    fire_err <= 1'b0;
    fire_arb <= 1'b0;
  endtask : ev
  task automatic wrap_up();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // events before communication starts leave everything at zero
    ev(1'b1, 8'h83, 1'b1, 5'h04);
    axr(8'h00, d, r);
    `CHK({r, d}, 34'h0)
    axw(8'h04, 32'h1, r);
    `CHK(r, 2'h0)
    // table: each row captured whole, then repeated with both flags clear
    foreach (rows[i]) begin
      ev(1'b1, rows[i].det, 1'b1, rows[i].pos);
      exp = {14'h0, 2'b11, 3'h0, rows[i].pos, rows[i].det};
      axr(8'h00, d, r);
      `CHK({r, d}, {2'h0, exp})
      axr(8'h00, d, r);
      `CHK(d, {16'h0, exp[15:0]})
      if (rows[i].det[5]) rxn++;
      else txn++;
    end
    axr(8'h08, d, r);
    `CHK(d, {16'h0, rxn, txn})
    // arbitration loss alone: counters untouched, error record kept stale
    ev(1'b0, 8'h00, 1'b1, 5'h05);
    axr(8'h08, d, r);
    `CHK(d, {16'h0, rxn, txn})
    axr(8'h00, d, r);
    `CHK(d, {14'h0, 2'b10, 3'h0, 5'h05, 8'h58})
    // back-to-back events: only the first of each kind is held
    ev(1'b1, 8'h83, 1'b1, 5'h07);
    ev(1'b1, 8'h31, 1'b1, 5'h09);
    axr(8'h00, d, r);
    `CHK(d, {14'h0, 2'b11, 3'h0, 5'h07, 8'h83})
    // segment zero is counted but never latched
    ev(1'b1, 8'hE0, 1'b0, 5'h00);
    axr(8'h00, d, r);
    `CHK(d, {16'h0, 5'h07, 8'h83})
    axr(8'h08, d, r);
    `CHK(d, {16'h0, rxn + 8'h02, txn + 8'h01})
    // unmapped place refused, capture word not writable
    axr(8'h0C, d, r);
    `CHK({r, d}, {2'h2, 32'h0})
    axw(8'h0C, 32'h1, r);
    `CHK(r, 2'h2)
    axw(8'h00, 32'hFFFFFFFF, r);
    `CHK(r, 2'h0)
    axr(8'h00, d, r);
    `CHK({r, d}, {2'h0, 16'h0, 5'h07, 8'h83})
    // a new start clears both records and counts
    axw(8'h04, 32'h0, r);
    axw(8'h04, 32'h1, r);
    axr(8'h00, d, r);
    `CHK(d, 32'h0)
    axr(8'h08, d, r);
    `CHK(d, 32'h0)
    // enable write with lane 0 off leaves communication running
    wstrb <= 4'hE;
    axw(8'h04, 32'h0, r);
    `CHK(r, 2'h0)
    wstrb <= 4'hF;
    axr(8'h04, d, r);
    `CHK({r, d}, 34'h1)
    // one held event, then a reset in mid-run clears records, counts and enable
    ev(1'b1, 8'hA3, 1'b1, 5'h1F);
    axr(8'h00, d, r);
    `CHK(d, {14'h0, 2'b11, 3'h0, 5'h1F, 8'hA3})
    `CHK(d & 32'h0003_1FFF, 32'h0003_1FA3)
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(8'h00, d, r);
    `CHK({r, d}, 34'h0)
    axr(8'h04, d, r);
    `CHK(d, 32'h0)
    axr(8'h08, d, r);
    `CHK(d, 32'h0)
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
